// >>> src/reload_down_timer.sv
// reloadable 8-bit down timer: apb register file, counter, zero flag
// assumes an apb3 master on clk_in and a pin synchronous to clk_in
//
// Notes on behaviour
// - run bit starts or stops decrementing
// - stopped counter holds its value
// - reset clears the run bit
// - count read as low and high nibble
// - writes to count nibbles are ignored
// - count undefined until first reload
// - enable bit zero readable, writable mask
// - reset clears the interrupt enable
// - flag set at zero regardless of enable
// - flag reads event state, writes ignored
// - reset clears the interrupt flag
// - reload zero gives 256 count period
// - zero reloads counter and keeps counting
// - decrement on falling input clock edge
// - strobe loads reload value, reads zero
// - three-bit selector picks input clock
`timescale 1ns/1ns
`default_nettype none
`include "timer_regs.svh"

module reload_down_timer #(
  parameter int unsigned PRESCALE_DIV = `TMR_PRESCALE_DIV,
  parameter int unsigned ADDR_W       = 14
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  // apb slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output var  logic [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // external count pin
  input  wire logic              external_count_input_in,
  // cpu interrupt request and selected clock monitor
  output logic                   irq_out,
  output var  logic              selected_clock_out
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  logic                timer_run_bit;
  logic                timer_irq_enable;
  logic                timer_irq_flag;
  logic                clock_out_enable;
  timer_pkg::clk_sel_t input_clock_select;
  logic [7:0]          reload_value;
  logic [7:0]          count;

  // bus decode
  timer_pkg::reg_index_t index;
  logic                  aligned;
  logic                  hit;
  logic                  access;
  logic                  wr_en;
  logic                  rd_done;
  logic [3:0]            wnib;
  logic [3:0]            next_rdata;

  // counter control
  logic timer_reload_strobe;
  logic zero_event;

  count_clock_if cc ();

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------

  // true when the register index is one that software may access
  function automatic logic is_mapped(input timer_pkg::reg_index_t idx);
    unique case (idx)
      `TMR_IDX_IRQ_FLAG,
      `TMR_IDX_IRQ_ENABLE,
      `TMR_IDX_COUNT_LOW,
      `TMR_IDX_COUNT_HIGH,
      `TMR_IDX_RELOAD_LOW,
      `TMR_IDX_RELOAD_HIGH,
      `TMR_IDX_RUN_CTRL,
      `TMR_IDX_CLOCK_CTRL: is_mapped = 1'b1;
      default:             is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // write strobe for one register index, taken in the access phase
  function automatic logic write_to(input logic en,
                                    input timer_pkg::reg_index_t cur,
                                    input timer_pkg::reg_index_t idx);
    write_to = en && (cur == idx);
  endfunction : write_to

  // ---------------------------------------------------------------------
  // apb decode: zero wait states, every access finishes in one access cycle
  // ---------------------------------------------------------------------
  assign index   = timer_pkg::reg_index_t'(paddr_in[ADDR_W-1:2]);
  assign aligned = (paddr_in[1:0] == 2'h0);
  assign hit     = aligned && is_mapped(index);
  assign access  = psel_in && penable_in;
  assign wr_en   = access && pwrite_in && hit;
  assign rd_done = access && !pwrite_in && hit;
  assign wnib    = pwdata_in[3:0];

  assign pready_out  = 1'b1;
  // unmapped or misaligned addresses answer with an error, no side effect
  assign pslverr_out = access && !hit;

  // ---------------------------------------------------------------------
  // control register: run bit and reload strobe
  // ---------------------------------------------------------------------

  // the run bit is kept across a reload; only software changes it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timer_run_bit <= `TMR_RST_RUN;
    end else if (write_to(wr_en, index, `TMR_IDX_RUN_CTRL)) begin
      timer_run_bit <= wnib[`TMR_BIT_RUN];
    end
  end

  // the strobe is write-only and exists only for the write cycle
  assign timer_reload_strobe = write_to(wr_en, index, `TMR_IDX_RUN_CTRL)
                               && wnib[`TMR_BIT_STROBE];

  // ---------------------------------------------------------------------
  // clock control: input selector and clock monitor enable
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      input_clock_select <= timer_pkg::clk_sel_t'(`TMR_RST_SELECT);
      clock_out_enable   <= `TMR_RST_CLOCK_OUT;
    end else if (write_to(wr_en, index, `TMR_IDX_CLOCK_CTRL)) begin
      input_clock_select <= timer_pkg::clk_sel_t'(wnib[`TMR_SEL_MSB:`TMR_SEL_LSB]);
      clock_out_enable   <= wnib[`TMR_BIT_CLOCK_OUT];
    end
  end

  assign cc.select = input_clock_select;

  // ---------------------------------------------------------------------
  // reload value: no reset, it is undefined until software writes it
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (write_to(wr_en, index, `TMR_IDX_RELOAD_LOW)) begin
      reload_value[3:0] <= wnib;
    end
    if (write_to(wr_en, index, `TMR_IDX_RELOAD_HIGH)) begin
      reload_value[7:4] <= wnib;
    end
  end

  // ---------------------------------------------------------------------
  // input clock: prescaler taps, pin filter and edge detection
  // ---------------------------------------------------------------------
  pin_noise_rejector u_filter (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .pin_in  (external_count_input_in),
    .cc      (cc.filter)
  );

  timer_clock_source #(
    .PRESCALE_DIV (PRESCALE_DIV)
  ) u_source (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .ext_direct_in (external_count_input_in),
    .cc            (cc.source)
  );

  // ---------------------------------------------------------------------
  // down counter
  // ---------------------------------------------------------------------

  // a tick that takes the count from 01 reaches zero; the reload is done in
  // the same edge so the readout goes straight from 01 to the reload value.
  // with a reload of 00 the count passes 00 then FF, a 256-tick period.
  assign zero_event = timer_run_bit && cc.count_tick
                      && !timer_reload_strobe && (count == 8'h01);

  // no reset: the count is undefined until the first reload
  always_ff @(posedge clk_in) begin
    if (timer_reload_strobe) begin
      count <= reload_value;
    end else if (timer_run_bit && cc.count_tick) begin
      if (count == 8'h01) begin
        count <= reload_value;
      end else begin
        count <= 8'(count - 8'h01);
      end
    end
    // otherwise the count is held, also while stopped
  end

  // ---------------------------------------------------------------------
  // interrupt flag and enable
  // ---------------------------------------------------------------------

  // the flag is cleared by software reading it; a zero event in the same
  // cycle as that read wins, but one in the setup cycle of the read is cleared unread
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timer_irq_flag <= `TMR_RST_IRQ_FLAG;
    end else if (zero_event) begin
      timer_irq_flag <= 1'b1;
    end else if (rd_done && (index == `TMR_IDX_IRQ_FLAG)) begin
      timer_irq_flag <= 1'b0;
    end
  end

  // the mask only gates the request, never the flag itself
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timer_irq_enable <= `TMR_RST_IRQ_ENABLE;
    end else if (write_to(wr_en, index, `TMR_IDX_IRQ_ENABLE)) begin
      timer_irq_enable <= wnib[`TMR_BIT_IRQ_ENABLE];
    end
  end

  assign irq_out = timer_irq_flag && timer_irq_enable;

  // ---------------------------------------------------------------------
  // read mux: built in the setup cycle so prdata comes from a flip-flop
  // ---------------------------------------------------------------------
  always_comb begin
    next_rdata = 4'h0;
    unique case (index)
      `TMR_IDX_IRQ_FLAG:    next_rdata[`TMR_BIT_IRQ_FLAG]   = timer_irq_flag;
      `TMR_IDX_IRQ_ENABLE:  next_rdata[`TMR_BIT_IRQ_ENABLE] = timer_irq_enable;
      `TMR_IDX_COUNT_LOW:   next_rdata = count[3:0];
      `TMR_IDX_COUNT_HIGH:  next_rdata = count[7:4];
      `TMR_IDX_RELOAD_LOW:  next_rdata = reload_value[3:0];
      `TMR_IDX_RELOAD_HIGH: next_rdata = reload_value[7:4];
      `TMR_IDX_RUN_CTRL:    next_rdata[`TMR_BIT_RUN] = timer_run_bit; // strobe reads 0
      `TMR_IDX_CLOCK_CTRL: begin
        next_rdata[`TMR_SEL_MSB:`TMR_SEL_LSB] = input_clock_select;
        next_rdata[`TMR_BIT_CLOCK_OUT]        = clock_out_enable;
      end
      default:              next_rdata = 4'h0;
    endcase
  end

  // the count nibbles have no write path at all
  // a running count can move between setup and access; software stops the
  // timer around a two-nibble read, which keeps both halves consistent
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in) begin
      prdata_out <= (!pwrite_in && hit) ? {28'h000_0000, next_rdata} : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------------
  // selected input clock monitor pin
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      selected_clock_out <= 1'b0;
    end else begin
      selected_clock_out <= clock_out_enable && cc.level;
    end
  end

endmodule : reload_down_timer

`default_nettype wire

// >>> src/timer_regs.svh
// register offsets, field positions, reset values and timing counts of the
// reloadable down timer; assumes a 100 MHz system clock on clk_in
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// register indices; the apb byte address is four times the index
`define TMR_IDX_IRQ_FLAG    12'hF02
`define TMR_IDX_IRQ_ENABLE  12'hF12
`define TMR_IDX_COUNT_LOW   12'hF24
`define TMR_IDX_COUNT_HIGH  12'hF25
`define TMR_IDX_RELOAD_LOW  12'hF26
`define TMR_IDX_RELOAD_HIGH 12'hF27
`define TMR_IDX_RUN_CTRL    12'hF78
`define TMR_IDX_CLOCK_CTRL  12'hF79

// field positions inside the 4-bit registers
`define TMR_BIT_IRQ_FLAG    0
`define TMR_BIT_IRQ_ENABLE  0
`define TMR_BIT_RUN         0
`define TMR_BIT_STROBE      1
`define TMR_BIT_CLOCK_OUT   3
`define TMR_SEL_MSB         2
`define TMR_SEL_LSB         0

// reset values
`define TMR_RST_RUN         1'h0
`define TMR_RST_IRQ_ENABLE  1'h0
`define TMR_RST_IRQ_FLAG    1'h0
`define TMR_RST_SELECT      3'h0
`define TMR_RST_CLOCK_OUT   1'h0
`define TMR_RST_EXT_LEVEL   1'h1

// timing: system clock rate and the toggle rate of the 8192 Hz tap
`define TMR_CLK_HZ          32'h05F5_E100
`define TMR_TAP_TOGGLE_HZ   32'h0000_4000
`define TMR_PRESCALE_DIV    (`TMR_CLK_HZ / `TMR_TAP_TOGGLE_HZ)

`endif

// >>> src/timer_pkg.sv
// types shared by the reloadable down timer modules
// assumes the constants of timer_regs.svh for offsets and counts
package timer_pkg;

  // input clock selector codes
  typedef enum logic [2:0] {
    SEL_EXT_FILTERED = 3'h0,
    SEL_EXT_DIRECT   = 3'h1,
    SEL_TAP_256      = 3'h2,
    SEL_TAP_512      = 3'h3,
    SEL_TAP_1024     = 3'h4,
    SEL_TAP_2048     = 3'h5,
    SEL_TAP_4096     = 3'h6,
    SEL_TAP_8192     = 3'h7
  } clk_sel_t;

  // register index as seen by software
  typedef logic [11:0] reg_index_t;

endpackage : timer_pkg

// >>> src/count_clock_if.sv
// signals between the timer core, its clock source and the pin filter
// assumes all three parties run on the same system clock
`timescale 1ns/1ns
`default_nettype none

interface count_clock_if;
  timer_pkg::clk_sel_t select;       // chosen input clock
  logic                sample_256;   // one pulse per 256 Hz period
  logic                ext_filtered; // debounced external pin level
  logic                level;        // selected input clock level
  logic                count_tick;   // falling edge of the selected clock

  modport source (input select, input ext_filtered,
                  output sample_256, output level, output count_tick);
  modport filter (input sample_256, output ext_filtered);
  modport sink   (output select, input level, input count_tick);
endinterface : count_clock_if

`default_nettype wire

// >>> src/pin_noise_rejector.sv
// debounce of the external count pin, sampled at 256 Hz
// assumes the pin is already synchronous to clk_in
`timescale 1ns/1ns
`default_nettype none
`include "timer_regs.svh"

module pin_noise_rejector (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // pin and filtered result
  input  wire logic pin_in,
  count_clock_if.filter cc
);
  logic last_sample;
  logic stable;

  // a level passes only after two equal samples: short chatter is dropped,
  // a level held for two sample periods always gets through
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_sample <= `TMR_RST_EXT_LEVEL;
      stable      <= `TMR_RST_EXT_LEVEL;
    end else if (cc.sample_256) begin
      last_sample <= pin_in;
      if (last_sample == pin_in) begin
        stable <= pin_in;
      end
    end
  end

  assign cc.ext_filtered = stable;
endmodule : pin_noise_rejector

`default_nettype wire

// >>> src/timer_clock_source.sv
// prescaler taps, input clock selection and falling edge detection
// assumes a system clock far faster than the 16384 Hz tap toggle rate
`timescale 1ns/1ns
`default_nettype none
`include "timer_regs.svh"

module timer_clock_source #(
  parameter int unsigned PRESCALE_DIV = `TMR_PRESCALE_DIV
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // raw external pin
  input  wire logic ext_direct_in,
  count_clock_if.source cc
);
  logic [31:0] div_count;
  logic        div_wrap;
  logic [5:0]  taps;
  logic        level;
  logic        prev_level;
  logic        next_level;

  assign div_wrap = (div_count == PRESCALE_DIV - 1);

  // divider: taps[0] toggles at 16384 Hz, so it is the 8192 Hz clock
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_count <= 32'h0000_0000;
      taps      <= 6'h00;
    end else if (div_wrap) begin
      div_count <= 32'h0000_0000;
      taps      <= 6'(taps + 6'h01);
    end else begin
      div_count <= 32'(div_count + 32'h0000_0001);
    end
  end

  assign cc.sample_256 = div_wrap && (taps == 6'h3F);

  // selector decode
  always_comb begin
    unique case (cc.select)
      timer_pkg::SEL_EXT_FILTERED: next_level = cc.ext_filtered;
      timer_pkg::SEL_EXT_DIRECT:   next_level = ext_direct_in;
      timer_pkg::SEL_TAP_256:      next_level = taps[5];
      timer_pkg::SEL_TAP_512:      next_level = taps[4];
      timer_pkg::SEL_TAP_1024:     next_level = taps[3];
      timer_pkg::SEL_TAP_2048:     next_level = taps[2];
      timer_pkg::SEL_TAP_4096:     next_level = taps[1];
      timer_pkg::SEL_TAP_8192:     next_level = taps[0];
    endcase
  end

  // registered level and its previous value for edge detection; both reset
  // to the idle pin level so no false edge follows reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      level      <= `TMR_RST_EXT_LEVEL;
      prev_level <= `TMR_RST_EXT_LEVEL;
    end else begin
      level      <= next_level;
      prev_level <= level;
    end
  end

  assign cc.level      = level;
  assign cc.count_tick = prev_level && !level;
endmodule : timer_clock_source

`default_nettype wire

// >>> tb/timer_props.sv
// concurrent checks of the reloadable down timer, seen from its top ports
// assumes one clock domain and the register indices of timer_regs.svh
`timescale 1ns/1ns
`default_nettype none
`include "timer_regs.svh"

module timer_props #(
  parameter int unsigned PRESCALE_DIV = 4,
  parameter int unsigned ADDR_W       = 14
) (
  // clock and reset
  input wire logic              clk_in,
  input wire logic              rstn_in,
  // apb slave
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic [31:0]       prdata_out,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  // pin, request and monitor
  input wire logic              external_count_input_in,
  input wire logic              irq_out,
  input wire logic              selected_clock_out
);
  logic [ADDR_W-3:0] idx;
  logic              aligned;
  logic              rd_acc;
  logic              wr_acc;
  logic              mapped;
  logic              en_shadow;

  // decode of the current transfer
  assign idx     = paddr_in[ADDR_W-1:2];
  assign aligned = (paddr_in[1:0] == 2'h0);
  assign rd_acc  = psel_in && penable_in && !pwrite_in;
  assign wr_acc  = psel_in && penable_in && pwrite_in;
  assign mapped  = aligned && (idx == `TMR_IDX_IRQ_FLAG || idx == `TMR_IDX_IRQ_ENABLE
                   || idx == `TMR_IDX_COUNT_LOW || idx == `TMR_IDX_COUNT_HIGH
                   || idx == `TMR_IDX_RELOAD_LOW || idx == `TMR_IDX_RELOAD_HIGH
                   || idx == `TMR_IDX_RUN_CTRL || idx == `TMR_IDX_CLOCK_CTRL);

  // mirror of the mask bit, so the request can be judged without internals
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      en_shadow <= `TMR_RST_IRQ_ENABLE;
    end else if (wr_acc && mapped && idx == `TMR_IDX_IRQ_ENABLE) begin
      en_shadow <= pwdata_in[`TMR_BIT_IRQ_ENABLE];
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_quiet_after_reset: assert property ($rose(rstn_in) |-> (!irq_out && !selected_clock_out) [*2])
    else $error("request or monitor active right after reset");
  a_irq_needs_mask: assert property (!en_shadow |-> !irq_out)
    else $error("request raised while masked");
  a_irq_holds: assert property (irq_out && !(psel_in && idx == `TMR_IDX_IRQ_FLAG)
      && !(psel_in && pwrite_in && idx == `TMR_IDX_IRQ_ENABLE) |=> irq_out)
    else $error("request dropped without flag read or mask write");
  a_mask_readback: assert property (rd_acc && mapped && idx == `TMR_IDX_IRQ_ENABLE
      |-> prdata_out[3:0] == {3'h0, en_shadow})
    else $error("mask bit reads back wrong");
  a_flag_upper_zero: assert property (rd_acc && mapped && idx == `TMR_IDX_IRQ_FLAG
      |-> prdata_out[3:1] == 3'h0)
    else $error("flag register upper bits not zero");
  a_strobe_reads_zero: assert property (rd_acc && mapped && idx == `TMR_IDX_RUN_CTRL
      |-> prdata_out[`TMR_BIT_STROBE] == 1'b0)
    else $error("reload strobe reads one");
  a_nibble_width: assert property (rd_acc |-> prdata_out[31:4] == 28'h0)
    else $error("read data wider than a nibble");
  a_count_write_quiet: assert property (wr_acc && aligned && (idx == `TMR_IDX_COUNT_LOW
      || idx == `TMR_IDX_COUNT_HIGH) |-> !pslverr_out && pready_out)
    else $error("count write answered with an error");
  a_unmapped_refused: assert property (psel_in && penable_in && !mapped
      |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");

  // main scenarios
  c_irq_cleared: cover property (irq_out ##1 !irq_out);
  c_refused: cover property (psel_in && penable_in && pslverr_out);
  c_monitor_rise: cover property ($rose(selected_clock_out));
endmodule : timer_props

bind reload_down_timer timer_props #(
  .PRESCALE_DIV(PRESCALE_DIV),
  .ADDR_W      (ADDR_W)
) chk (
  .clk_in                 (clk_in),
  .rstn_in                (rstn_in),
  .psel_in                (psel_in),
  .penable_in             (penable_in),
  .pwrite_in              (pwrite_in),
  .paddr_in               (paddr_in),
  .pwdata_in              (pwdata_in),
  .prdata_out             (prdata_out),
  .pready_out             (pready_out),
  .pslverr_out            (pslverr_out),
  .external_count_input_in(external_count_input_in),
  .irq_out                (irq_out),
  .selected_clock_out     (selected_clock_out)
);

`default_nettype wire

// >>> tb/tb_reload_down_timer.sv
// self-checking bench of the reloadable down timer over apb
// assumes the checker is bound in and a shortened prescaler of 4
`timescale 1ns/1ns
`default_nettype none
`include "timer_regs.svh"

module tb_reload_down_timer;
  localparam int unsigned PDIV = 4;
  localparam logic [11:0] FLG  = `TMR_IDX_IRQ_FLAG;
  localparam logic [11:0] ENA  = `TMR_IDX_IRQ_ENABLE;
  localparam logic [11:0] RUNC = `TMR_IDX_RUN_CTRL;
  localparam logic [11:0] CLKC = `TMR_IDX_CLOCK_CTRL;
  // design stimulus and outputs
  logic        clk_in;
  logic        rstn_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [13:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_pin;
  logic        irq;
  logic        sel_clk;
  // bench state
  logic [31:0] rdata;
  logic        rerr;
  logic        prev;
  logic [7:0]  seed;
  logic [7:0]  r;
  logic [7:0]  m;
  int          fails;
  int          total_checks;
  int          n;

  reload_down_timer #(.PRESCALE_DIV(PDIV), .ADDR_W(14)) dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .external_count_input_in(ext_pin),
    .irq_out(irq), .selected_clock_out(sel_clk));

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // count after some ticks; 01 is replaced by the reload at once
  function automatic logic [7:0] exp_after(input logic [7:0] rl, input logic [7:0] st,
                                           input int ticks);
    logic [7:0] v;
    v = st;
    for (int i = 0; i < ticks; i++) begin
      v = (v == 8'h01) ? rl : v - 8'h01;
    end
    return v;
  endfunction : exp_after

  // the fastest tap has a period of two prescaler steps
  function automatic int tap_rises(input int s, input int win);
    return win / ((2 * PDIV) << (7 - s));
  endfunction : tap_rises

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_near(input int got, input int exp, input int tol);
    total_checks++;
    if (got < exp - tol || got > exp + tol) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_near

  // one apb transfer; held until pready is seen at a rising edge
  task automatic xfer(input logic wr_en, input logic [11:0] idx, input logic [3:0] wd);
    int i;
    @(posedge clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= {idx, 2'h0};
    pwdata  <= {28'h0, wd};
    @(posedge clk_in);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) fails++;
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] idx, input logic [3:0] wd);
    xfer(1'b1, idx, wd);
  endtask : wr

  task automatic rd(input logic [11:0] idx);
    xfer(1'b0, idx, 4'h0);
  endtask : rd

  // no latching between halves, so the counter must be idle while read
  task automatic chk_count(input logic [7:0] exp);
    logic [7:0] got;
    rd(`TMR_IDX_COUNT_LOW);
    got[3:0] = rdata[3:0];
    rd(`TMR_IDX_COUNT_HIGH);
    got[7:4] = rdata[3:0];
    cmp({24'h0, got}, {24'h0, exp});
  endtask : chk_count

  // falling then rising edge on the pin, each level held four cycles
  task automatic pulse(input int cnt);
    repeat (cnt) begin
      @(posedge clk_in);
      ext_pin <= 1'b0;
      repeat (4) @(posedge clk_in);
      ext_pin <= 1'b1;
      repeat (4) @(posedge clk_in);
    end
    repeat (4) @(posedge clk_in);
  endtask : pulse

  task automatic stop_test();
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // watchdog well above the expected run of about 17000 cycles
  initial begin
    repeat (90000) @(posedge clk_in);
    fails++;
    stop_test();
  end

  initial begin
    clk_in = 1'b0;
    rstn_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0;
    pwdata = 32'h0;
    ext_pin = 1'b1;
    prev = 1'b0;
    fails = 0;
    total_checks = 0;
    seed = 8'h40;
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    // reset values and the mask bit
    rd(FLG);
    cmp(rdata, 32'h0);
    rd(ENA);
    cmp(rdata, 32'h0);
    rd(RUNC);
    cmp(rdata, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    wr(ENA, 4'hF);
    rd(ENA);
    cmp(rdata, 32'h1);
    wr(ENA, 4'h0);
    rd(ENA);
    cmp(rdata, 32'h0);
    rd(12'hF03);
    cmp({31'h0, rerr}, 32'h1);
    wr(CLKC, {1'b0, timer_pkg::SEL_EXT_DIRECT});
    // random reloads, the smallest legal one first
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      r = (k == 0) ? 8'h02 : (seed | 8'h02);
      m = r >> 1;
      wr(RUNC, 4'h0);
      wr(`TMR_IDX_RELOAD_LOW, r[3:0]);
      wr(`TMR_IDX_RELOAD_HIGH, r[7:4]);
      wr(RUNC, 4'h2);
      chk_count(r);
      wr(`TMR_IDX_COUNT_LOW, ~r[3:0]);
      wr(`TMR_IDX_COUNT_HIGH, ~r[7:4]);
      chk_count(r);
      pulse(3);
      chk_count(r);
      wr(RUNC, 4'h1);
      pulse(int'(m));
      wr(RUNC, 4'h0);
      chk_count(exp_after(r, r, int'(m)));
      wr(RUNC, 4'h1);
      wr(ENA, {3'h0, k[0]});
      pulse(int'(r) - int'(m));
      chk_count(exp_after(r, r, int'(r)));
      cmp({31'h0, irq}, {31'h0, k[0]});
      wr(FLG, 4'h0);
      rd(FLG);
      cmp(rdata, 32'h1);
      rd(FLG);
      cmp(rdata, 32'h0);
      pulse(1);
      wr(RUNC, 4'h3);
      chk_count(r);
    end
    // reload of zero gives the full period
    wr(RUNC, 4'h0);
    wr(`TMR_IDX_RELOAD_LOW, 4'h0);
    wr(`TMR_IDX_RELOAD_HIGH, 4'h0);
    wr(RUNC, 4'h2);
    wr(RUNC, 4'h1);
    pulse(255);
    chk_count(exp_after(8'h00, 8'h00, 255));
    rd(FLG);
    cmp(rdata, 32'h0);
    pulse(1);
    chk_count(exp_after(8'h00, 8'h00, 256));
    rd(FLG);
    cmp(rdata, 32'h1);
    wr(RUNC, 4'h0);
    // prescaler taps seen on the monitor pin
    for (int s = 2; s < 8; s++) begin
      wr(CLKC, 4'(8 + s));
      n = 0;
      repeat (2048) begin
        @(posedge clk_in);
        if (sel_clk === 1'b1 && prev === 1'b0) n++;
        prev = sel_clk;
      end
      cmp_near(n, tap_rises(s, 2048), 1);
    end
    // filtered pin needs two equal slow samples, direct pin passes at once
    wr(CLKC, 4'h8);
    ext_pin <= 1'b0;
    repeat (1000) @(posedge clk_in);
    cmp({31'h0, sel_clk}, 32'h0);
    ext_pin <= 1'b1;
    repeat (1000) @(posedge clk_in);
    cmp({31'h0, sel_clk}, 32'h1);
    wr(CLKC, 4'h9);
    ext_pin <= 1'b0;
    repeat (8) @(posedge clk_in);
    cmp({31'h0, sel_clk}, 32'h0);
    stop_test();
  end
endmodule : tb_reload_down_timer

`default_nettype wire
